/* logic/spv_consts.vh */
// Purpose: constants for the serial program/verify port.
// Assumes: included by bare name from the design files that use it.
// Notes:   counts are in ref_clk cycles at 100 MHz.
//
// Functional notes
// R1: Programmer holds clock and data low while mode select rises to high voltage.
// R2: Entering the mode holds other logic in reset, I/O as inputs.
// R3: Commands are six clocks, captured on falling edge, LSb first.
// R4: Data phase is 16 clocks: start bit, word LSb first, stop bit.
// R5: Programmer waits at least 1 us between command and data phase.
// R6: Read phase drives LSb on the rising edge of cycle two.
// R7: Load phase captures LSb on the falling edge of cycle two.
// R8: Programmer waits at least 1 us before the next command.
// R9: Sender changes data on rising edges, receiver samples on falling edges.
// R10: User memory uses only the low 10 counter bits, upper 3 ignored.
// R11: Addresses 0000h-1FFFh are user memory, 2000h-3FFFh configuration.
// R12: Counter wraps 1FFFh to 0000h and 3FFFh to 2000h.
// R13: Once in configuration space the counter top bit stays set.
// R14: Configuration locations 2000h-200Fh exist, only 2000h-2007h usable.
// R15: Identification words 2000h-2003h read true even when code protected.
// R16: Programmer should write ID words as 11 1111 1000 plus four bits.
// R17: Load configuration sets counter to 2000h, then loads a 14-bit word.
// R18: Mode select below logic low leaves the mode.
// R19: Programmer loads, programs, verifies, then increments each location.
// R20: Load program data takes a 14-bit word at the current address.
// R21: Read drives data pin from second rising edge, releases at sixteenth.
// R22: Increment address advances the counter at once with wrap rules.
// R23: Unknown command codes are ignored with no state change.

`ifndef SPV_CONSTS_VH
`define SPV_CONSTS_VH

// Frame sizes.
`define SPV_CMD_BITS      6
`define SPV_CMD_LAST      4'h5
`define SPV_WORD_BITS     14
`define SPV_FRAME_LAST    4'hF
`define SPV_PC_BITS       14

// Command codes, MSb on the left.
`define SPV_CMD_LOAD_CFG  6'h00
`define SPV_CMD_LOAD_PROG 6'h02
`define SPV_CMD_READ_PROG 6'h04
`define SPV_CMD_INC_ADDR  6'h06

// Address map.
`define SPV_PC_RESET      14'h0000
`define SPV_PC_CFG_BASE   14'h2000
`define SPV_PC_ID_LAST    14'h2003
`define SPV_PC_CFG_LAST   14'h2007
`define SPV_USER_BITS     10
`define SPV_CFG_BITS      4

// Least gap the programmer leaves between frames.
`define SPV_GAP_NS        1000
`define SPV_CLK_MHZ       100
`define SPV_GAP_CYC       ((`SPV_GAP_NS * `SPV_CLK_MHZ + 999) / 1000)

`endif

/* logic/spv_sync.v */
// Purpose: two-stage synchroniser for a group of pin inputs.
// Assumes: each bit is an independent level.
// Notes:   first stage feeds only the second stage.

`timescale 1ns/1ps

module spv_sync #(
	parameter WIDTH = 4
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// Two flip-flops settle each level into the clock domain.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= asyncIn;
			sync_reg <= meta_reg;
		end
	end

	assign syncOut = sync_reg;

endmodule

/* logic/spv_pc.v */
// Purpose: program counter with split user and configuration spaces.
// Assumes: at most one of clear, setCfg and inc per cycle matters.
// Notes:   clear has priority, then setCfg, then inc.

`timescale 1ns/1ps
`include "spv_consts.vh"

module spv_pc (
	input  wire                    clk,
	input  wire                    rstn,
	input  wire                    clear,
	input  wire                    setCfg,
	input  wire                    inc,
	output wire [`SPV_PC_BITS-1:0] pc
);

	reg  [`SPV_PC_BITS-1:0] pc_reg;
	wire [`SPV_PC_BITS-2:0] lowInc;

	// Lower bits count on their own, so an increment never changes the top bit.
	assign lowInc = pc_reg[`SPV_PC_BITS-2:0] + 1'b1;

	// Counter update on mode entry, load configuration or increment.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_reg <= `SPV_PC_RESET;
		end else if (clear) begin
			// R13: entry clears space
			pc_reg <= `SPV_PC_RESET;
		end else if (setCfg) begin
			// R17: jump to 2000h
			pc_reg <= `SPV_PC_CFG_BASE;
		end else if (inc) begin
			// R12: wrap within space
			pc_reg <= {pc_reg[`SPV_PC_BITS-1], lowInc};
		end
	end

	assign pc = pc_reg;

endmodule

/* logic/spv_port.v */
// Purpose: serial program/verify port, device side.
// Assumes: pins and mode detectors are asynchronous to ref_clk.
// Notes:   the serial clock is sampled, so it must be well below ref_clk.

`timescale 1ns/1ps
`include "spv_consts.vh"

module spv_port (
	input  wire                     ref_clk,
	input  wire                     rstn,
	input  wire                     serialClkPin,
	input  wire                     serialDataIn,
	input  wire                     modeSelectHv,
	input  wire                     modeSelectLow,
	input  wire                     codeProtect,
	input  wire [`SPV_WORD_BITS-1:0] memRdData,
	output reg                      serialDataOut,
	output reg                      serialDataOe,
	output reg                      progMode,
	output reg                      coreResetHold,
	output reg  [`SPV_USER_BITS-1:0] memAddr,
	output reg                      memCfgSel,
	output reg                      memCfgReserved,
	output reg                      memLoadStrobe,
	output reg  [`SPV_WORD_BITS-1:0] memLoadData
);

	// ****************************************
	// States
	// ****************************************

	localparam [2:0] ST_OFF  = 3'h1;
	localparam [2:0] ST_CMD  = 3'h2;
	localparam [2:0] ST_DATA = 3'h4;

	// ****************************************
	// Declarations
	// ****************************************

	wire [3:0]                syncOut;
	wire                      sclk;
	wire                      sdat;
	wire                      hv;
	wire                      lowLvl;
	wire                      sclkRise;
	wire                      sclkFall;
	wire                      enterMode;
	wire [`SPV_PC_BITS-1:0]   pcVal;
	wire [`SPV_WORD_BITS-1:0] rdWord;
	wire [`SPV_CMD_BITS-1:0]  cmdWord;

	reg                       sclkPrev_reg;
	reg                       hvPrev_reg;
	reg                       lowSeen_reg;
	reg  [2:0]                state_reg;
	reg  [2:0]                state_next;
	reg  [3:0]                bitCnt_reg;
	reg  [3:0]                bitCnt_next;
	reg  [`SPV_CMD_BITS-1:0]  cmdShift_reg;
	reg  [`SPV_CMD_BITS-1:0]  cmdShift_next;
	reg  [`SPV_WORD_BITS-1:0] datShift_reg;
	reg  [`SPV_WORD_BITS-1:0] datShift_next;
	reg                       isRead_reg;
	reg                       isRead_next;
	reg                       dout_next;
	reg                       oe_next;
	reg                       strobe_next;
	reg  [`SPV_WORD_BITS-1:0] ldData_next;
	reg                       pcClear;
	reg                       pcSetCfg;
	reg                       pcInc;

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Every pin level passes two flip-flops before use.
	spv_sync #(
		.WIDTH (4)
	) uSync (
		.clk     (ref_clk),
		.rstn    (rstn),
		.asyncIn ({modeSelectLow, modeSelectHv, serialDataIn, serialClkPin}),
		.syncOut (syncOut)
	);

	// Names for the settled pin levels.
	assign sclk   = syncOut[0];
	assign sdat   = syncOut[1];
	assign hv     = syncOut[2];
	assign lowLvl = syncOut[3];

	// R9: edges of serial clock
	assign sclkRise = sclk & ~sclkPrev_reg;
	assign sclkFall = ~sclk & sclkPrev_reg;

	// R1: entry needs low pins
	assign enterMode = hv & ~hvPrev_reg & ~sclk & ~sdat & lowSeen_reg;

	// R3: LSb first, newest bit on top
	assign cmdWord = {sdat, cmdShift_reg[`SPV_CMD_BITS-1:1]};

	// ****************************************
	// Program counter
	// ****************************************

	// Counter with the space wrap rules.
	spv_pc uPc (
		.clk    (ref_clk),
		.rstn   (rstn),
		.clear  (pcClear),
		.setCfg (pcSetCfg),
		.inc    (pcInc),
		.pc     (pcVal)
	);

	// R15: only user space is masked
	assign rdWord = (codeProtect & ~pcVal[`SPV_PC_BITS-1]) ?
		{`SPV_WORD_BITS{1'b0}} : memRdData;

	// ****************************************
	// Frame engine
	// ****************************************

	// Next-state logic for commands and data phases.
	always @* begin
		state_next    = state_reg;
		bitCnt_next   = bitCnt_reg;
		cmdShift_next = cmdShift_reg;
		datShift_next = datShift_reg;
		isRead_next   = isRead_reg;
		dout_next     = serialDataOut;
		oe_next       = serialDataOe;
		strobe_next   = 1'b0;
		ldData_next   = memLoadData;
		pcClear       = 1'b0;
		pcSetCfg      = 1'b0;
		pcInc         = 1'b0;
		case (state_reg)
			ST_OFF: begin
				oe_next   = 1'b0;
				dout_next = 1'b0;
				if (enterMode) begin
					state_next  = ST_CMD;
					bitCnt_next = 4'h0;
					// R13: fresh entry to user space
					pcClear     = 1'b1;
				end
			end
			ST_CMD: begin
				if (lowLvl) begin
					// R18: mode exit
					state_next = ST_OFF;
				end else if (sclkFall) begin
					// R3: shift command bit
					cmdShift_next = cmdWord;
					if (bitCnt_reg == `SPV_CMD_LAST) begin
						bitCnt_next   = 4'h0;
						datShift_next = {`SPV_WORD_BITS{1'b0}};
						case (cmdWord)
							`SPV_CMD_LOAD_CFG: begin
								// R17: point at configuration
								pcSetCfg    = 1'b1;
								isRead_next = 1'b0;
								state_next  = ST_DATA;
							end
							`SPV_CMD_LOAD_PROG: begin
								// R20: load at current address
								isRead_next = 1'b0;
								state_next  = ST_DATA;
							end
							`SPV_CMD_READ_PROG: begin
								isRead_next = 1'b1;
								state_next  = ST_DATA;
							end
							`SPV_CMD_INC_ADDR: begin
								// R22: advance at once
								pcInc = 1'b1;
							end
							default: begin
								// R23: unknown code ignored
								isRead_next = isRead_reg;
							end
						endcase
					end else begin
						bitCnt_next = bitCnt_reg + 4'h1;
					end
				end
			end
			ST_DATA: begin
				if (lowLvl) begin
					// R18: mode exit mid frame
					state_next = ST_OFF;
					oe_next    = 1'b0;
					dout_next  = 1'b0;
				end else if (sclkRise) begin
					// R4: bitCnt holds falls seen so far
					if (isRead_reg) begin
						if (bitCnt_reg == 4'h0) begin
							// Word is captured at the start bit.
							datShift_next = rdWord;
						end else if (bitCnt_reg == `SPV_FRAME_LAST) begin
							// R21: release after stop edge
							oe_next   = 1'b0;
							dout_next = 1'b0;
						end else begin
							// R6: drive next bit
							oe_next       = 1'b1;
							dout_next     = datShift_reg[0];
							datShift_next = {1'b0, datShift_reg[`SPV_WORD_BITS-1:1]};
						end
					end
				end else if (sclkFall) begin
					// R7: capture word bits
					if (!isRead_reg && bitCnt_reg != 4'h0 &&
						bitCnt_reg != `SPV_FRAME_LAST) begin
						datShift_next = {sdat, datShift_reg[`SPV_WORD_BITS-1:1]};
					end
					if (bitCnt_reg == `SPV_FRAME_LAST) begin
						// R4: stop bit ends frame
						state_next  = ST_CMD;
						bitCnt_next = 4'h0;
						oe_next     = 1'b0;
						dout_next   = 1'b0;
						if (!isRead_reg) begin
							strobe_next = 1'b1;
							ldData_next = datShift_reg;
						end
					end else begin
						bitCnt_next = bitCnt_reg + 4'h1;
					end
				end
			end
			default: begin
				state_next = ST_OFF;
				oe_next    = 1'b0;
				dout_next  = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************

	// Frame state and pin history.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclkPrev_reg <= 1'b0;
			hvPrev_reg   <= 1'b0;
			lowSeen_reg  <= 1'b0;
			state_reg    <= ST_OFF;
			bitCnt_reg   <= 4'h0;
			cmdShift_reg <= 6'h00;
			datShift_reg <= 14'h0000;
			isRead_reg   <= 1'b0;
		end else begin
			sclkPrev_reg <= sclk;
			hvPrev_reg   <= hv;
			// R1: pin must start from logic low
			if (lowLvl) begin
				lowSeen_reg <= 1'b1;
			end else if (hv & ~hvPrev_reg) begin
				lowSeen_reg <= 1'b0;
			end
			state_reg    <= state_next;
			bitCnt_reg   <= bitCnt_next;
			cmdShift_reg <= cmdShift_next;
			datShift_reg <= datShift_next;
			isRead_reg   <= isRead_next;
		end
	end

	// Registered outputs.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			serialDataOut  <= 1'b0;
			serialDataOe   <= 1'b0;
			progMode       <= 1'b0;
			coreResetHold  <= 1'b0;
			memAddr        <= 10'h000;
			memCfgSel      <= 1'b0;
			memCfgReserved <= 1'b0;
			memLoadStrobe  <= 1'b0;
			memLoadData    <= 14'h0000;
		end else begin
			serialDataOut <= dout_next;
			serialDataOe  <= oe_next;
			progMode      <= (state_next != ST_OFF);
			// R2: core and I/O held in reset
			coreResetHold <= (state_next != ST_OFF);
			// R10: low bits address user array
			// R11: top bit picks the space
			if (pcVal[`SPV_PC_BITS-1]) begin
				memAddr <= {6'h00, pcVal[`SPV_CFG_BITS-1:0]};
			end else begin
				memAddr <= pcVal[`SPV_USER_BITS-1:0];
			end
			memCfgSel <= pcVal[`SPV_PC_BITS-1];
			// R14: above 2007h is reserved
			memCfgReserved <= pcVal[`SPV_PC_BITS-1] & (pcVal > `SPV_PC_CFG_LAST);
			memLoadStrobe  <= strobe_next;
			memLoadData    <= ldData_next;
		end
	end

endmodule

/* dv/spv_port_chk.sv */
// Purpose: assertions on the program/verify port pins.
// Assumes: bound to spv_port, one clock domain.
// Notes:   pin timing is seen through the input synchroniser.
`timescale 1ns/1ps
module spv_port_chk (
	input logic       ref_clk,
	input logic       rstn,
	input logic       serialClkPin,
	input logic       modeSelectLow,
	input logic       serialDataOut,
	input logic       serialDataOe,
	input logic       progMode,
	input logic       coreResetHold,
	input logic [9:0] memAddr,
	input logic       memCfgSel,
	input logic       memCfgReserved,
	input logic       memLoadStrobe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic [3:0] sinceRise_reg;
	// ********************
	// Checks
	// ********************
	// Cycles since the serial clock rose, held at the top.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			sinceRise_reg <= 4'hF;
		else if ($rose(serialClkPin))
			sinceRise_reg <= 4'h0;
		else if (sinceRise_reg != 4'hF)
			sinceRise_reg <= sinceRise_reg + 4'h1;
	end
	// A configuration-space cycle inside the mode that the mode outlasts by one cycle.
	// The entry cycle is excluded, since the select lags the cleared counter there.
	sequence cfgHeld;
		memCfgSel && progMode && $past(progMode) ##1 progMode;
	endsequence
	AST_CORE_HOLD: assert property (coreResetHold == progMode)
		else $error("core hold differs from mode");
	AST_HOLD_EXIT: assert property (progMode && modeSelectLow |-> ##[1:4] !coreResetHold)
		else $error("core hold outlasts mode exit");
	AST_OE_IN_MODE: assert property (serialDataOe |-> progMode)
		else $error("data pin driven outside mode");
	AST_OUT_IDLE: assert property (!serialDataOe |-> !serialDataOut)
		else $error("data out high while released");
	AST_STROBE_ONE: assert property (memLoadStrobe |=> !memLoadStrobe)
		else $error("load strobe longer than a cycle");
	AST_CFG_STICKY: assert property (cfgHeld |-> memCfgSel)
		else $error("left configuration space");
	AST_RSV_CFG: assert property (memCfgReserved |-> memCfgSel)
		else $error("reserved flag in user space");
	AST_CFG_ALIAS: assert property (memCfgSel [*2] |-> memAddr[9:4] == 6'h00)
		else $error("configuration address too wide");
	AST_ENTRY_USER: assert property ($rose(progMode) |-> ##2 !memCfgSel)
		else $error("entry not in user space");
	AST_EDGE_TIED: assert property (progMode && $changed(serialDataOe) |->
		sinceRise_reg inside {[4'h1:4'h6]})
		else $error("data pin turned away from clock rise");
endmodule
bind spv_port spv_port_chk chk (
	.ref_clk       (ref_clk),
	.rstn          (rstn),
	.serialClkPin  (serialClkPin),
	.modeSelectLow (modeSelectLow),
	.serialDataOut (serialDataOut),
	.serialDataOe  (serialDataOe),
	.progMode      (progMode),
	.coreResetHold (coreResetHold),
	.memAddr       (memAddr),
	.memCfgSel     (memCfgSel),
	.memCfgReserved(memCfgReserved),
	.memLoadStrobe (memLoadStrobe)
);

/* dv/spv_prog_model.sv */
// Purpose: programmer model driving clock, data and mode select.
// Assumes: called at a ref_clk rising edge.
// Notes:   serial clock period is 8 ref_clk cycles, idle low.
`timescale 1ns/1ps
module spv_prog_model (
	input  logic ref_clk,
	input  logic serialDataOut,
	input  logic serialDataOe,
	output logic serialClkPin,
	output logic serialDataIn,
	output logic modeSelectHv,
	output logic modeSelectLow
);
	logic progOe = 1'b1;
	logic progBit = 1'b0;
	logic lastWire = 1'b0;
	// ********************
	// Data line
	// ********************
	// An undriven line flips each cycle so stale bits never pass.
	assign serialDataIn = serialDataOe ? serialDataOut : (progOe ? progBit : ~lastWire);
	always @(posedge ref_clk) lastWire <= serialDataIn;
	initial begin
		serialClkPin = 1'b0;
		modeSelectHv = 1'b0;
		modeSelectLow = 1'b1;
	end
	task automatic bitCyc(input logic b, input logic drv, output logic r);
		serialClkPin <= 1'b1;
		progBit <= b;
		progOe <= drv;
		repeat (4) @(posedge ref_clk);
		serialClkPin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		r = serialDataIn;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic sendCmd(input logic [5:0] code);
		logic r;
		for (int i = 0; i < 6; i++) bitCyc(code[i], 1'b1, r);
		repeat (100) @(posedge ref_clk);
	endtask
	task automatic dataPhase(input logic [13:0] wIn, input logic rd, output logic [13:0] wOut);
		logic [15:0] f;
		logic [15:0] rf;
		f = {1'b0, wIn, 1'b0};
		for (int i = 0; i < 16; i++) bitCyc(f[i], !rd, rf[i]);
		wOut = rf[14:1];
		progOe <= 1'b1;
		repeat (100) @(posedge ref_clk);
	endtask
	task automatic enterMode();
		progBit <= 1'b0;
		progOe <= 1'b1;
		modeSelectLow <= 1'b1;
		repeat (8) @(posedge ref_clk);
		modeSelectLow <= 1'b0;
		repeat (8) @(posedge ref_clk);
		modeSelectHv <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic exitMode();
		modeSelectHv <= 1'b0;
		modeSelectLow <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule

/* dv/tb_top.sv */
// Purpose: self-checking bench for spv_port.
// Assumes: spv_consts.vh on the include path.
// Notes:   memory contents are held by the bench.
`timescale 1ns/1ps
`include "spv_consts.vh"
`define CHK(nm, e, a) begin cmpCount++; if ((a) !== (e)) begin failCount++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_top;
	logic        ref_clk;
	logic        rstn;
	logic        codeProtect;
	logic        serialClkPin;
	logic        serialDataIn;
	logic        modeSelectHv;
	logic        modeSelectLow;
	logic        serialDataOut;
	logic        serialDataOe;
	logic        progMode;
	logic        coreResetHold;
	logic [9:0]  memAddr;
	logic        memCfgSel;
	logic        memCfgReserved;
	logic        memLoadStrobe;
	logic [13:0] memLoadData;
	logic [13:0] memRdData = 14'h0000;
	logic [13:0] userMem [1024];
	logic [13:0] cfgMem [16];
	logic [7:0]  strobeCnt = 8'h00;
	int          oeCnt = 0;
	int          failCount = 0;
	int          cmpCount = 0;
	int          cycles = 0;
	logic [13:0] w;
	spv_port uut (.ref_clk(ref_clk), .rstn(rstn), .serialClkPin(serialClkPin),
		.serialDataIn(serialDataIn), .modeSelectHv(modeSelectHv),
		.modeSelectLow(modeSelectLow), .codeProtect(codeProtect), .memRdData(memRdData),
		.serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .progMode(progMode),
		.coreResetHold(coreResetHold), .memAddr(memAddr), .memCfgSel(memCfgSel),
		.memCfgReserved(memCfgReserved), .memLoadStrobe(memLoadStrobe),
		.memLoadData(memLoadData));
	spv_prog_model prog (.ref_clk(ref_clk), .serialDataOut(serialDataOut),
		.serialDataOe(serialDataOe), .serialClkPin(serialClkPin),
		.serialDataIn(serialDataIn), .modeSelectHv(modeSelectHv),
		.modeSelectLow(modeSelectLow));
	// ********************
	// Memory and watchdog
	// ********************
	// Memory answers the port, stores loads and bounds the run.
	always @(posedge ref_clk) begin
		memRdData <= memCfgSel ? cfgMem[memAddr[3:0]] : userMem[memAddr];
		if (serialDataOe) oeCnt <= oeCnt + 1;
		cycles <= cycles + 1;
		if (memLoadStrobe) begin
			strobeCnt <= strobeCnt + 8'h01;
			if (memCfgSel) cfgMem[memAddr[3:0]] <= memLoadData;
			else userMem[memAddr] <= memLoadData;
		end
		if (cycles == 20000) begin
			failCount++;
			endSim();
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic endSim();
		if (failCount == 0 && cmpCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Entry lands in user space with the core held.
	task automatic scnEntry();
		`CHK("mode", 1'b0, progMode)
		prog.enterMode();
		`CHK("mode", 1'b1, progMode)
		`CHK("hold", 1'b1, coreResetHold)
		`CHK("sel", 1'b0, memCfgSel)
		`CHK("addr", 10'h000, memAddr)
	endtask
	// Load, read back, protected read, increment.
	task automatic scnLoadRead();
		prog.sendCmd(`SPV_CMD_LOAD_PROG);
		prog.dataPhase(14'h2A5C, 1'b0, w);
		`CHK("strobes", 8'h01, strobeCnt)
		`CHK("mem0", 14'h2A5C, userMem[0])
		prog.sendCmd(`SPV_CMD_READ_PROG);
		prog.dataPhase(14'h0000, 1'b1, w);
		`CHK("read", 14'h2A5C, w)
		`CHK("oe", 1'b0, serialDataOe)
		codeProtect <= 1'b1;
		prog.sendCmd(`SPV_CMD_READ_PROG);
		prog.dataPhase(14'h0000, 1'b1, w);
		`CHK("masked", 14'h0000, w)
		prog.sendCmd(`SPV_CMD_INC_ADDR);
		`CHK("inc", 10'h001, memAddr)
	endtask
	// Unknown codes leave the data pin, load strobe and address alone.
	task automatic scnUnknown();
		int base;
		base = oeCnt;
		prog.sendCmd(6'h08);
		prog.sendCmd(6'h01);
		prog.sendCmd(6'h3F);
		`CHK("oeCnt", base, oeCnt)
		`CHK("strobes", 8'h01, strobeCnt)
		prog.sendCmd(`SPV_CMD_INC_ADDR);
		`CHK("addr", 10'h002, memAddr)
	endtask
	// Configuration load, ID read and reserved area.
	task automatic scnConfig();
		prog.sendCmd(`SPV_CMD_LOAD_CFG);
		`CHK("sel", 1'b1, memCfgSel)
		`CHK("addr", 10'h000, memAddr)
		prog.dataPhase(14'h3F85, 1'b0, w);
		`CHK("cfg0", 14'h3F85, cfgMem[0])
		prog.sendCmd(`SPV_CMD_READ_PROG);
		prog.dataPhase(14'h0000, 1'b1, w);
		`CHK("id", 14'h3F85, w)
		for (int i = 0; i < 7; i++) prog.sendCmd(`SPV_CMD_INC_ADDR);
		`CHK("rsv", 1'b0, memCfgReserved)
		prog.sendCmd(`SPV_CMD_INC_ADDR);
		`CHK("addr", 10'h008, memAddr)
		`CHK("rsv", 1'b1, memCfgReserved)
		`CHK("sel", 1'b1, memCfgSel)
	endtask
	// Exit and re-entry return to user space.
	task automatic scnExit();
		prog.exitMode();
		`CHK("mode", 1'b0, progMode)
		`CHK("oe", 1'b0, serialDataOe)
		prog.enterMode();
		`CHK("sel", 1'b0, memCfgSel)
		`CHK("addr", 10'h000, memAddr)
	endtask
	// A read cut short by mode exit releases the data pin.
	task automatic scnAbort();
		logic r;
		prog.sendCmd(`SPV_CMD_READ_PROG);
		prog.bitCyc(1'b0, 1'b0, r);
		prog.bitCyc(1'b0, 1'b0, r);
		`CHK("oeMid", 1'b1, serialDataOe)
		prog.exitMode();
		`CHK("mode", 1'b0, progMode)
		`CHK("oe", 1'b0, serialDataOe)
		prog.enterMode();
		`CHK("mode", 1'b1, progMode)
	endtask
	initial begin
		rstn = 1'b0;
		codeProtect = 1'b0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		scnEntry();
		scnLoadRead();
		scnUnknown();
		scnConfig();
		scnExit();
		scnAbort();
		endSim();
	end
endmodule
